//--- bench/css_config_select_properties.sv
// Port checker for the configuration front end, bound to its top module
`timescale 1ns/1ns
module css_config_select_properties import css_pkg::*; #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Shared and strap pins
  input wire logic serialPortEnablePin,
  input wire logic busWidthSelect,
  input wire logic clockModeSelect,
  input wire logic clockModeSelectOut,
  input wire logic clockModeSelectDriveN,
  input wire logic latchEdge,
  input wire logic lowSwing,
  input wire logic powerDownN,
  input wire logic deskewEnable,
  input wire logic receiverDetected,
  input wire logic monitorSenseProgOut,
  input wire logic monitorSenseProgOutDriveN,
  input wire css_cfg_t cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  localparam int LAT = SYNC_STAGES + 1; // Pin to output latency
  logic [2:0] lowCnt; // Settled cycles in strap mode
  logic [2:0] highCnt; // Settled cycles in serial mode
  logic diffIn; // Strap clock decode from the raw pins
  assign diffIn = clockModeSelect & ~busWidthSelect & lowSwing;
  // Count how long the select pin has held its level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= 3'h0;
      highCnt <= 3'h0;
    end else begin
      lowCnt <= serialPortEnablePin ? 3'h0 : lowCnt + {2'h0, lowCnt != 3'h7};
      highCnt <= serialPortEnablePin ? highCnt + {2'h0, highCnt != 3'h7} : 3'h0;
    end
  end
  property p_width;
    lowCnt > 3'h4 |-> cfg.wide24 == $past(busWidthSelect, LAT) && !cfg.serialActive
      && cfg.deskewOn == $past(deskewEnable, LAT);
  endproperty
  a_width: assert property (p_width) else $error("strap width or deskew wrong");
  property p_diff;
    lowCnt > 3'h4 |-> cfg.diffClock == $past(diffIn, LAT);
  endproperty
  a_diff: assert property (p_diff) else $error("strap clock mode wrong");
  property p_swing;
    !$past(lowSwing, LAT) |-> !cfg.diffClock;
  endproperty
  a_swing: assert property (p_swing) else $error("differential with high swing");
  property p_latch;
    lowCnt > 3'h4 |-> cfg.latchRising == $past(latchEdge, LAT);
  endproperty
  a_latch: assert property (p_latch) else $error("latch edge wrong");
  property p_power;
    lowCnt > 3'h4 |-> cfg.powerDown != $past(powerDownN, LAT);
  endproperty
  a_power: assert property (p_power) else $error("power state wrong");
  property p_sense;
    lowCnt > 3'h4 |-> monitorSenseProgOutDriveN != $past(receiverDetected, LAT);
  endproperty
  a_sense: assert property (p_sense) else $error("sense pin wrong");
  property p_od;
    !monitorSenseProgOut && !clockModeSelectOut;
  endproperty
  a_od: assert property (p_od) else $error("open drain pin drives high");
  property p_nodata;
    lowCnt > 3'h4 |-> clockModeSelectDriveN;
  endproperty
  a_nodata: assert property (p_nodata) else $error("data pulled in strap mode");
  property p_serial;
    highCnt > 3'h4 |-> cfg.serialActive;
  endproperty
  a_serial: assert property (p_serial) else $error("serial mode not active");
  property p_fresh;
    $rose(cfg.serialActive) |-> cfg == 6'h22;
  endproperty
  a_fresh: assert property (p_fresh) else $error("registers not at defaults");
endmodule
bind css_config_select css_config_select_properties #(.SYNC_STAGES(SYNC_STAGES)) chk_i (
  .clk(clk), .resetn(resetn), .serialPortEnablePin(serialPortEnablePin),
  .busWidthSelect(busWidthSelect), .clockModeSelect(clockModeSelect),
  .clockModeSelectOut(clockModeSelectOut), .clockModeSelectDriveN(clockModeSelectDriveN),
  .latchEdge(latchEdge), .lowSwing(lowSwing), .powerDownN(powerDownN),
  .deskewEnable(deskewEnable), .receiverDetected(receiverDetected),
  .monitorSenseProgOut(monitorSenseProgOut),
  .monitorSenseProgOutDriveN(monitorSenseProgOutDriveN), .cfg(cfg));

//--- bench/css_config_select_tb_top.sv
// Self-checking bench for the configuration front end
`include "css_defs.svh"
`timescale 1ns/1ns
module css_config_select_tb_top import css_pkg::*;;
  logic clk = 1'b0; // 25 MHz clock
  logic resetn = 1'b0; // Async reset
  css_pins_t pins = '0; // Strap levels and select
  logic scl, sda, dataDriveN, senseDriveN; // Serial lines and pulls
  css_cfg_t cfg; // Effective configuration
  logic [7:0] wa = {`CSS_TARGET_ADDR, 1'b0}; // Write address byte
  int errors = 0;
  int check_count = 0;
  css_config_select css_config_select_i (.clk(clk), .resetn(resetn),
    .serialPortEnablePin(pins.serialPortEnablePin),
    .busWidthSelect(pins.serialPortEnablePin ? scl : pins.busWidthSelect),
    .clockModeSelect(pins.serialPortEnablePin ? sda : pins.clockModeSelect),
    .clockModeSelectOut(), .clockModeSelectDriveN(dataDriveN), .latchEdge(pins.latchEdge),
    .lowSwing(pins.lowSwing), .powerDownN(pins.powerDownN), .deskewEnable(pins.deskewEnable),
    .receiverDetected(pins.receiverDetected), .monitorSenseProgOut(),
    .monitorSenseProgOutDriveN(senseDriveN), .cfg(cfg));
  css_i2c_host css_i2c_host_i (.clk(clk), .devDriveN(dataDriveN), .scl(scl), .sda(sda));
  always #20 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strap decode expected from the pin levels
  function automatic css_cfg_t expCfg(css_pins_t p);
    return '{1'b0, p.busWidthSelect, p.clockModeSelect & !p.busWidthSelect & p.lowSwing,
      p.latchEdge, !p.powerDownN, p.deskewEnable};
  endfunction
  // Register write, acknowledge bits returned
  task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
    output logic [2:0] k);
    logic [7:0] q;
    css_i2c_host_i.start();
    css_i2c_host_i.xbyte(a, 1'b1, q, k[2]);
    css_i2c_host_i.xbyte(r, 1'b1, q, k[1]);
    css_i2c_host_i.xbyte(d, 1'b1, q, k[0]);
    css_i2c_host_i.stop();
  endtask
  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [2:0] k;
    logic [7:0] q;
    void'($urandom(32'h9901BA0B));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    // Straps: differential corner, all low, then random
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      pins <= i == 0 ? 8'h5D : i == 1 ? 8'h00 : 8'($urandom) & 8'hFD;
      repeat (5) @(posedge clk);
      check(8'(cfg), 8'(expCfg(pins)));
      check(8'(senseDriveN), 8'(!pins.receiverDetected));
    end
    // Serial mode with random straps that must be ignored
    pins <= 8'($urandom) | 8'h12;
    repeat (8) @(posedge clk);
    check(8'(cfg), 8'h22);
    check(8'(senseDriveN), 8'h01);
    wr(wa, `CSS_REG_CTL, 8'h1F, k);
    check(8'(k), 8'h00);
    check(8'(cfg), 8'h3D);
    wr(wa, `CSS_REG_PROG, 8'h00, k);
    check(8'(senseDriveN), 8'h00);
    // Readback of the status byte after a repeated start
    css_i2c_host_i.start();
    css_i2c_host_i.xbyte(wa, 1'b1, q, k[0]);
    css_i2c_host_i.xbyte(`CSS_REG_STAT, 1'b1, q, k[0]);
    css_i2c_host_i.start();
    css_i2c_host_i.xbyte(wa | 8'h01, 1'b1, q, k[0]);
    css_i2c_host_i.xbyte(8'hFF, 1'b1, q, k[0]);
    css_i2c_host_i.stop();
    check(q, {6'h00, 1'b1, pins.receiverDetected});
    // High swing in serial mode must drop the differential clock bit
    pins.lowSwing <= 1'b0;
    repeat (4) @(posedge clk);
    check(8'(cfg), 8'h35);
    // Slow host to a foreign address is refused
    css_i2c_host_i.halfCycles = 14;
    wr(wa ^ 8'h02, `CSS_REG_PROG, 8'h01, k);
    check(8'(k), 8'h07);
    // Select pulse low resets every register to its default
    pins.serialPortEnablePin <= 1'b0;
    repeat (6) @(posedge clk);
    check(8'(cfg), 8'(expCfg(pins)));
    pins.serialPortEnablePin <= 1'b1;
    repeat (8) @(posedge clk);
    check(8'(cfg), 8'h22);
    check(8'(senseDriveN), 8'h01);
    conclude();
  end
  // Watchdog against a hung transfer
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule

//--- bench/css_i2c_host.sv
// Behavioural serial host on the shared clock and data pins
`timescale 1ns/1ns
module css_i2c_host (
  // Clock
  input wire logic clk,
  // Device pull on the data line, low when pulling
  input wire logic devDriveN,
  // Resolved line levels
  output logic scl,
  output logic sda
);
  logic sclLow = 1'b0; // Host pulls clock low
  logic sdaLow = 1'b0; // Host pulls data low
  int halfCycles = 10; // Clocks per half bit, raised for a slow host
  // Both lines idle high through pull-ups
  assign scl = !sclLow;
  assign sda = !sdaLow && devDriveN;
  task automatic half();
    repeat (halfCycles) @(posedge clk);
  endtask
  // Start, also usable as a repeated start
  task automatic start();
    sdaLow <= 1'b0;
    half();
    sclLow <= 1'b0;
    half();
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b1;
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b0;
    half();
    sdaLow <= 1'b0;
    half();
  endtask
  // One bit out, the line level read back at the end of the high phase
  task automatic xbit(input logic b, output logic r);
    sdaLow <= !b;
    half();
    sclLow <= 1'b0;
    half();
    r = sda;
    sclLow <= 1'b1;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(last, ack);
  endtask
endmodule

//--- verilog/css_config_select.sv
// Strap or serial configuration select, pin routing and serial target registers
// Operation
// RULE1: Strap mode: sense pin low when receiver present
// RULE2: Serial mode: sense pin follows software register
// RULE3: Sense pin is open-drain, external pull-up
// RULE4: Select high enables target, registers at defaults
// RULE5: Select low: configuration comes from strap pins
// RULE6: Select low-high pulse resets target asynchronously
// RULE7: Width pin high 24-bit single, low 12-bit dual
// RULE8: Serial mode: width pin clock, mode pin data
// RULE9: Clock mode decoded from mode, width, swing
// RULE10: Differential clocking only with low swing
// RULE11: Latch strap high rising, low falling edge
// RULE12: Power pin high normal, low power-down
// RULE13: Serial mode uses register values, not straps
`include "css_defs.svh"
`timescale 1ns/1ns
module css_config_select import css_pkg::*; #(
  parameter logic [6:0] TARGET_ADDR = `CSS_TARGET_ADDR,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Interface select pin, also serial reset
  input wire logic serialPortEnablePin,
  // Width select pin, serial clock in serial mode
  input wire logic busWidthSelect,
  // Clock mode pin, serial data in serial mode
  input wire logic clockModeSelect,
  output logic clockModeSelectOut,
  output logic clockModeSelectDriveN,
  // Other strap and state pins
  input wire logic latchEdge,
  input wire logic lowSwing,
  input wire logic powerDownN,
  input wire logic deskewEnable,
  // Receiver detection result from the output stage
  input wire logic receiverDetected,
  // Monitor sense open-drain pin
  output logic monitorSenseProgOut,
  output logic monitorSenseProgOutDriveN,
  // Effective configuration
  output css_cfg_t cfg
);
  // Refuse a synchroniser too short for asynchronous pins
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  css_pins_t pinsRaw; // Pin levels straight from the pads
  css_pins_t pins; // Pin levels after synchronisation
  logic [1:0] serialRstChain; // Reset release chain of the serial side
  logic serialRstN; // Serial side reset, active low
  logic sclPrev; // Serial clock one cycle ago
  logic sdaPrev; // Serial data one cycle ago
  logic startSeen; // Start condition
  logic stopSeen; // Stop condition
  logic sclRise; // Serial clock rising edge
  logic sclFall; // Serial clock falling edge
  css_state_t state; // Serial target state
  logic [3:0] bitCnt; // Bits of the current byte
  logic [7:0] shift; // Byte shift register
  logic readMode; // Current transfer reads
  logic firstByte; // Next written byte is the pointer
  logic [7:0] pointer; // Register pointer
  logic [7:0] regCtl; // Control register
  logic [7:0] regProg; // Programmable output register
  logic [7:0] readData; // Register read mux
  logic sdaLow; // Target pulls serial data low
  css_cfg_t next_cfg; // Configuration before the output flop

  // Collect pins and pass them through the synchroniser
  assign pinsRaw = '{busWidthSelect: busWidthSelect, clockModeSelect: clockModeSelect,
                     latchEdge: latchEdge, lowSwing: lowSwing, powerDownN: powerDownN,
                     deskewEnable: deskewEnable, serialPortEnablePin: serialPortEnablePin,
                     receiverDetected: receiverDetected};
  css_sync #(
    .WIDTH(`CSS_PIN_COUNT),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(pinsRaw),
    .dout(pins)
  );

  // Select pin low clears the serial side at once; release is synchronous
  always_ff @(posedge clk or negedge resetn or negedge serialPortEnablePin) begin
    if (!resetn || !serialPortEnablePin) begin
      serialRstChain <= 2'h0; // RULE6
    end else begin
      serialRstChain <= {serialRstChain[0], 1'b1};
    end
  end
  assign serialRstN = serialRstChain[1];

  // Edge history of the serial lines
  always_ff @(posedge clk or negedge serialRstN) begin
    if (!serialRstN) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= pins.busWidthSelect; // RULE8
      sdaPrev <= pins.clockModeSelect;
    end
  end

  // Bus conditions, valid only with the serial side enabled
  assign startSeen = pins.busWidthSelect & sclPrev & sdaPrev & ~pins.clockModeSelect;
  assign stopSeen = pins.busWidthSelect & sclPrev & ~sdaPrev & pins.clockModeSelect;
  assign sclRise = pins.busWidthSelect & ~sclPrev;
  assign sclFall = ~pins.busWidthSelect & sclPrev;

  // Register read mux
  always_comb begin
    readData = 8'h00;
    unique case (pointer)
      `CSS_REG_CTL: readData = regCtl;
      `CSS_REG_PROG: readData = regProg;
      `CSS_REG_STAT: begin
        readData[`CSS_STAT_RX_DET] = pins.receiverDetected;
        readData[`CSS_STAT_LOW_SWING] = pins.lowSwing;
      end
      default: readData = 8'h00;
    endcase
  end

  // Serial target state machine
  always_ff @(posedge clk or negedge serialRstN) begin
    if (!serialRstN) begin
      state <= ST_IDLE; // RULE4
      bitCnt <= 4'h0;
      shift <= 8'h00;
      readMode <= 1'b0;
      firstByte <= 1'b1;
    end else if (startSeen) begin
      // Start or repeated start opens a new address byte
      state <= ST_ADDR;
      bitCnt <= 4'h0;
      firstByte <= 1'b1;
    end else if (stopSeen) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          bitCnt <= 4'h0;
        end
        ST_ADDR, ST_WRITE: begin
          if (sclRise && bitCnt != 4'h8) begin
            // Sample a data bit
            shift <= {shift[6:0], pins.clockModeSelect};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == 4'h8) begin
            bitCnt <= 4'h0;
            if (state == ST_ADDR) begin
              // Acknowledge own address only
              if (shift[7:1] == TARGET_ADDR) begin
                readMode <= shift[0];
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              firstByte <= 1'b0;
              state <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            // Acknowledge clock ends; go read or take more bytes
            bitCnt <= 4'h0;
            if (readMode) begin
              shift <= readData;
              state <= ST_READ;
            end else begin
              state <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (sclFall) begin
            if (bitCnt == 4'h7) begin
              bitCnt <= 4'h0;
              state <= ST_RACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise && pins.clockModeSelect) begin
            // Host did not acknowledge: transfer ends
            state <= ST_IDLE;
          end else if (sclFall) begin
            shift <= readData;
            state <= ST_READ;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pointer and register writes; reads advance the pointer
  always_ff @(posedge clk or negedge serialRstN) begin
    if (!serialRstN) begin
      pointer <= 8'h00;
      regCtl <= `CSS_CTL_RESET; // RULE6
      regProg <= `CSS_PROG_RESET;
    end else if (!startSeen && !stopSeen) begin
      if (state == ST_WRITE && sclFall && bitCnt == 4'h8) begin
        if (firstByte) begin
          pointer <= shift;
        end else begin
          if (pointer == `CSS_REG_CTL) begin
            regCtl <= shift;
          end
          if (pointer == `CSS_REG_PROG) begin
            regProg <= shift;
          end
          pointer <= pointer + 8'h01;
        end
      end else if (sclFall && ((state == ST_ACK && readMode) || state == ST_RACK)) begin
        pointer <= pointer + 8'h01;
      end
    end
  end

  // Target pulls data low for acknowledge and for zero read bits
  assign sdaLow = pins.serialPortEnablePin &&
                  (state == ST_ACK || (state == ST_READ && !shift[7]));
  assign clockModeSelectOut = 1'b0;
  assign clockModeSelectDriveN = ~sdaLow; // RULE8

  // Monitor sense: open-drain, pulls low or releases
  assign monitorSenseProgOut = 1'b0; // RULE3
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitorSenseProgOutDriveN <= 1'b1;
    end else if (pins.serialPortEnablePin) begin
      monitorSenseProgOutDriveN <= regProg[`CSS_PROG_OUT]; // RULE2
    end else begin
      monitorSenseProgOutDriveN <= ~pins.receiverDetected; // RULE1
    end
  end

  // Effective configuration: registers in serial mode, straps otherwise
  always_comb begin
    next_cfg = '0;
    next_cfg.serialActive = pins.serialPortEnablePin;
    if (pins.serialPortEnablePin) begin
      next_cfg.wide24 = regCtl[`CSS_CTL_WIDE24]; // RULE13
      next_cfg.latchRising = regCtl[`CSS_CTL_LATCH_RISE];
      next_cfg.powerDown = ~regCtl[`CSS_CTL_PWR_NORMAL];
      next_cfg.deskewOn = regCtl[`CSS_CTL_DESKEW];
      next_cfg.diffClock = regCtl[`CSS_CTL_DIFF_CLK] & pins.lowSwing; // RULE10
    end else begin
      next_cfg.wide24 = pins.busWidthSelect; // RULE5 RULE7
      next_cfg.latchRising = pins.latchEdge; // RULE11
      next_cfg.powerDown = ~pins.powerDownN; // RULE12
      next_cfg.deskewOn = pins.deskewEnable;
      next_cfg.diffClock = pins.clockModeSelect & ~pins.busWidthSelect & pins.lowSwing; // RULE9
    end
  end

  // Configuration output flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end
endmodule

//--- verilog/css_defs.svh
// Register offsets, field positions and reset values of the configuration front end
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH
// Register offsets seen through the serial target port
`define CSS_REG_CTL 8'h08
`define CSS_REG_PROG 8'h09
`define CSS_REG_STAT 8'h0A
// Control register fields
`define CSS_CTL_PWR_NORMAL 0
`define CSS_CTL_LATCH_RISE 1
`define CSS_CTL_WIDE24 2
`define CSS_CTL_DIFF_CLK 3
`define CSS_CTL_DESKEW 4
// Programmable output register field
`define CSS_PROG_OUT 0
// Status register fields
`define CSS_STAT_RX_DET 0
`define CSS_STAT_LOW_SWING 1
// Register reset values
`define CSS_CTL_RESET 8'h00
`define CSS_PROG_RESET 8'h01
// Default 7-bit target address
`define CSS_TARGET_ADDR 7'h38
// Number of synchronised pin inputs
`define CSS_PIN_COUNT 8
`endif

//--- verilog/css_pkg.sv
// Types shared by the configuration front end
package css_pkg;
  // Pin levels after synchronisation
  typedef struct packed {
    logic busWidthSelect;
    logic clockModeSelect;
    logic latchEdge;
    logic lowSwing;
    logic powerDownN;
    logic deskewEnable;
    logic serialPortEnablePin;
    logic receiverDetected;
  } css_pins_t;
  // Effective device configuration
  typedef struct packed {
    logic serialActive;
    logic wide24;
    logic diffClock;
    logic latchRising;
    logic powerDown;
    logic deskewOn;
  } css_cfg_t;
  // Serial target states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ = 6'h10,
    ST_RACK = 6'h20
  } css_state_t;
endpackage

//--- verilog/css_sync.sv
// Multi-bit two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module css_sync #(
  parameter int WIDTH = 8,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // Refuse a chain too short to let a metastable first stage settle
  if (STAGES < 2) begin : g_bad_stages
    $error("css_sync needs at least two stages");
  end
  // One shift chain per bit; only the last stage is read outside
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic [STAGES-1:0] chain;
      // Shift the pin level along the chain
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          chain <= '0;
        end else begin
          chain <= {chain[STAGES-2:0], din[gi]};
        end
      end
      assign dout[gi] = chain[STAGES-1];
    end
  endgenerate
endmodule
